// ---- common/tpw_defs.svh ----
// register offsets, field positions and reset values of the pwm timer
// assumes a 32-bit ahb-lite bus: byte address is four times the index
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH

// register indices, byte address = index * 4
`define TPW_IDX_IRQ_FLAGS      8'h35
`define TPW_IDX_CONTROL_A      8'h44
`define TPW_IDX_CONTROL_B      8'h45
`define TPW_IDX_COUNT_VALUE    8'h46
`define TPW_IDX_COMPARE_A      8'h47
`define TPW_IDX_COMPARE_B      8'h48
`define TPW_IDX_TRIGGER_SEL    8'h49
`define TPW_IDX_DEAD_TIME      8'h4f
`define TPW_IDX_IRQ_MASK       8'h6e
`define TPW_IDX_CLOCK_CTRL     8'hec

// control a fields
`define TPW_CA_MODE_A_HI       7
`define TPW_CA_MODE_A_LO       6
`define TPW_CA_MODE_B_HI       5
`define TPW_CA_MODE_B_LO       4
`define TPW_CA_SHUT_B          3
`define TPW_CA_SHUT_A          2
`define TPW_CA_WAVE_HI         1
`define TPW_CA_WAVE_LO         0

// control b fields
`define TPW_CB_DEAD_EN         4
`define TPW_CB_WAVE_TOP        3
`define TPW_CB_CS_HI           2
`define TPW_CB_CS_LO           0
`define TPW_CB_WR_MASK         8'h3f

// clock control fields and flag field
`define TPW_CK_MULT_EN         0
`define TPW_CK_FAST_SEL        1
`define TPW_FL_OVERFLOW        0

// reset value of every register, and the count maximum
`define TPW_REG_RESET          8'h00
`define TPW_COUNT_MAX          8'hff

// waveform modes with phase-correct counting
`define TPW_WM_PC_FULL         3'h1
`define TPW_WM_PC_CMPA         3'h5

// output modes
`define TPW_OM_OFF             2'h0
`define TPW_OM_CLR_UP          2'h2
`define TPW_OM_SET_UP          2'h3

// prescale divide masks (divide minus one)
`define TPW_PS_DIV8            10'h007
`define TPW_PS_DIV64           10'h03f
`define TPW_PS_DIV256          10'h0ff
`define TPW_PS_DIV1024         10'h3ff

`endif

// ---- common/tpw_pkg.sv ----
// types shared by the pwm timer: bus carriers, pin carrier and state
// widths are written as literals here; tpw_defs.svh is not included
package tpw_pkg;

    // counting direction
    typedef enum logic {
        TPW_UP   = 1'b0,
        TPW_DOWN = 1'b1
    } tpw_dir_t;

    // ahb-lite request side as seen by the slave
    typedef struct packed {
        logic        hsel;
        logic [11:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } tpw_ahb_req_t;

    // ahb-lite response side
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } tpw_ahb_rsp_t;

    // compare pins toward the power stage
    typedef struct packed {
        logic out_a;
        logic oe_a;
        logic out_b;
        logic oe_b;
    } tpw_pins_t;

    // whole state of the timer
    typedef struct packed {
        logic [1:0] fast_sync;
        logic       fast_prev;
        logic [7:0] control_a;
        logic [7:0] control_b;
        logic [7:0] count;
        tpw_dir_t   dir;
        logic [7:0] cmp_buf_a;
        logic [7:0] cmp_buf_b;
        logic [7:0] cmp_act_a;
        logic [7:0] cmp_act_b;
        logic [7:0] trig_sel;
        logic [7:0] dead_len;
        logic [7:0] irq_mask;
        logic [7:0] clk_ctl;
        logic       ovf;
        logic       wave_a;
        logic       wave_b;
        logic [9:0] prescale;
        logic       shut_a;
        logic       shut_b;
        logic [7:0] trig_prev;
        logic [7:0] dt_cnt_a;
        logic [7:0] dt_cnt_b;
        logic       out_a;
        logic       out_b;
        logic       dp_valid;
        logic       dp_write;
        logic       dp_hit;
        logic [7:0] dp_idx;
        logic [7:0] rdata;
    } tpw_state_t;

endpackage

// ---- logic/tpw_timer.sv ----
// 8-bit phase-correct pwm timer with dead-time and ahb-lite registers
// assumes one clock; the fast oscillator arrives as a sampled input
//
// Operation
// [RULE1] counting clock is system clock over 1..1024
// [RULE2] up-match and down-match drive opposite levels
// [RULE3] compare at min or max holds constant
// [RULE4] leaving 0xff toggles output at top
// [RULE5] missed match from above also toggles output
// [RULE6] dead-time derives both outputs from channel b
// [RULE7] equal output modes give equal polarity
// [RULE8] dead-time off: channels run independently
// [RULE9] fast select counts on multiplied oscillator clock
// [RULE10] software enables multiplier before fast select
// [RULE11] software spaces back-to-back fast-domain accesses
// [RULE12] software stops counter before reading count
// [RULE13] dual-domain registers work in both clocks
// [RULE14] control a output-mode fields connect pins
// [RULE15] control a bit 3 enables channel b shutdown
// [RULE16] control a bit 2 enables channel a shutdown
// [RULE17] control a low bits are waveform mode
// [RULE18] modes 1 and 5 count up-down
// [RULE19] overflow at bottom, compare reload at top
// [RULE20] mode 2 clears on up, 3 inverse
// [RULE21] dead interval delays only active-going edges
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "tpw_defs.svh"

module tpw_timer #(
    parameter int PRESCALE_W = 10
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire tpw_pkg::tpw_ahb_req_t ahb_req,
    output tpw_pkg::tpw_ahb_rsp_t      ahb_rsp,
    input  wire logic                  fast_rc_osc_clock,
    input  wire logic [7:0]            trigger_events,
    input  wire logic                  pin_dir_a,
    input  wire logic                  pin_dir_b,
    output logic                       osc_multiplier_enable,
    output tpw_pkg::tpw_pins_t         pins
);

    // the prescaler divides by up to 1024, so narrower widths cannot serve
    if (PRESCALE_W != 10) begin : g_bad_width
        $error("tpw_timer: PRESCALE_W must be 10");
    end

    tpw_pkg::tpw_state_t st;
    tpw_pkg::tpw_state_t next_st;

    logic [2:0] waveform_mode;
    logic [1:0] output_mode_a;
    logic [1:0] output_mode_b;
    logic [2:0] clock_select;
    logic       dead_time_enable;
    logic       fast_clock_select;
    logic       phase_correct_pwm;
    logic       base_tick;
    logic       tick;
    logic [7:0] top;
    logic [7:0] ncnt;
    tpw_pkg::tpw_dir_t ndir;
    logic       at_top;
    logic       at_bottom;
    logic [7:0] trig_rise;
    logic       addr_phase;
    logic [7:0] addr_idx;
    logic       addr_ok;
    logic       wr_en;
    logic [7:0] wdata;
    logic       ref_a;

    // prescale mask for a clock select code; zero means every base tick
    function automatic logic [9:0] ps_mask(input logic [2:0] cs);
        case (cs)
            3'h2:    ps_mask = `TPW_PS_DIV8;
            3'h3:    ps_mask = `TPW_PS_DIV64;
            3'h4:    ps_mask = `TPW_PS_DIV256;
            3'h5:    ps_mask = `TPW_PS_DIV1024;
            default: ps_mask = 10'h000;
        endcase
    endfunction

    // level an output takes after an up-count match
    function automatic logic up_level(input logic [1:0] om);
        up_level = (om == `TPW_OM_SET_UP);
    endfunction

    // one step of the active-edge delay: returns {out, count}
    function automatic logic [8:0] dt_step(
        input logic       ref_lvl,
        input logic       cur,
        input logic [7:0] cnt,
        input logic [7:0] len,
        input logic       tk
    );
        if (!ref_lvl) begin
            dt_step = 9'h000;
        end else if (cur) begin
            dt_step = {1'b1, cnt};
        end else if (cnt >= len) begin
            dt_step = {1'b1, cnt};
        end else if (tk) begin
            dt_step = {1'b0, 8'(cnt + 8'h01)};
        end else begin
            dt_step = {1'b0, cnt};
        end
    endfunction

    // register read view of a state copy
    function automatic logic [7:0] rd_reg(
        input tpw_pkg::tpw_state_t s,
        input logic [7:0]          idx
    );
        case (idx)
            `TPW_IDX_IRQ_FLAGS:   rd_reg = {7'h00, s.ovf};
            `TPW_IDX_CONTROL_A:   rd_reg = s.control_a;
            `TPW_IDX_CONTROL_B:   rd_reg = s.control_b & `TPW_CB_WR_MASK;
            `TPW_IDX_COUNT_VALUE: rd_reg = s.count;
            `TPW_IDX_COMPARE_A:   rd_reg = s.cmp_buf_a;
            `TPW_IDX_COMPARE_B:   rd_reg = s.cmp_buf_b;
            `TPW_IDX_TRIGGER_SEL: rd_reg = s.trig_sel;
            `TPW_IDX_DEAD_TIME:   rd_reg = s.dead_len;
            `TPW_IDX_IRQ_MASK:    rd_reg = s.irq_mask;
            `TPW_IDX_CLOCK_CTRL:  rd_reg = s.clk_ctl;
            default:              rd_reg = 8'h00;
        endcase
    endfunction

    // field decode of the control registers
    assign output_mode_a = st.control_a[`TPW_CA_MODE_A_HI:`TPW_CA_MODE_A_LO];
    assign output_mode_b = st.control_a[`TPW_CA_MODE_B_HI:`TPW_CA_MODE_B_LO];
    assign waveform_mode = {st.control_b[`TPW_CB_WAVE_TOP],
                            st.control_a[`TPW_CA_WAVE_HI:`TPW_CA_WAVE_LO]};
    assign clock_select      = st.control_b[`TPW_CB_CS_HI:`TPW_CB_CS_LO];
    assign dead_time_enable  = st.control_b[`TPW_CB_DEAD_EN];
    assign fast_clock_select = st.clk_ctl[`TPW_CK_FAST_SEL];
    assign phase_correct_pwm = (waveform_mode == `TPW_WM_PC_FULL) ||
                               (waveform_mode == `TPW_WM_PC_CMPA);

    // base tick: every system clock, or a sampled fast-oscillator edge
    assign base_tick = fast_clock_select ?
                       (st.fast_sync[1] & ~st.fast_prev) : 1'b1; // [RULE9]
    // codes 6 and 7 (external pin) are not served and stop the count
    assign tick = base_tick && (clock_select >= 3'h1) &&
                  (clock_select <= 3'h5) &&
                  ((st.prescale & ps_mask(clock_select)) ==
                   ps_mask(clock_select)); // [RULE1]

    // up-down counter, turns at each end without repeating the end value
    assign top = (waveform_mode == `TPW_WM_PC_CMPA) ?
                 st.cmp_act_a : `TPW_COUNT_MAX; // [RULE18]
    always_comb begin
        ncnt = st.count;
        ndir = st.dir;
        if (st.dir == tpw_pkg::TPW_UP) begin
            if (st.count >= top) begin
                ncnt = (top == 8'h00) ? 8'h00 : 8'(top - 8'h01);
                ndir = tpw_pkg::TPW_DOWN;
            end else begin
                ncnt = 8'(st.count + 8'h01);
            end
        end else begin
            if (st.count == 8'h00) begin
                ncnt = (top == 8'h00) ? 8'h00 : 8'h01;
                ndir = tpw_pkg::TPW_UP;
            end else begin
                ncnt = 8'(st.count - 8'h01);
            end
        end
    end
    assign at_top    = (ndir == tpw_pkg::TPW_UP) && (ncnt == top);
    assign at_bottom = (ndir == tpw_pkg::TPW_DOWN) && (ncnt == 8'h00);

    // bus decode; hready is our own hreadyout, so one cycle per phase
    assign addr_phase = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    assign addr_ok    = (ahb_req.haddr[11:10] == 2'h0) &&
                        (ahb_req.haddr[1:0] == 2'h0);
    assign addr_idx   = ahb_req.haddr[9:2];
    assign wr_en      = st.dp_valid && st.dp_write && st.dp_hit;
    assign wdata      = ahb_req.hwdata[7:0];

    // selected trigger sources, rising edges only
    assign trig_rise = trigger_events & ~st.trig_prev & st.trig_sel;

    // reference for output a under dead-time
    assign ref_a = (output_mode_a == output_mode_b) ?
                   st.wave_b : ~st.wave_b; // [RULE7]

    // next-state logic: bus, counter, waveforms, shutdown, dead-time
    always_comb begin
        logic [8:0] step_a;
        logic [8:0] step_b;
        logic       lvl_a;
        logic       lvl_b;
        next_st = st;
        step_a  = 9'h000;
        step_b  = 9'h000;
        lvl_a   = 1'b0;
        lvl_b   = 1'b0;

        // fast clock sampler: only the second stage is looked at
        next_st.fast_sync = {st.fast_sync[0], fast_rc_osc_clock};
        next_st.fast_prev = st.fast_sync[1];
        next_st.trig_prev = trigger_events;

        // prescaler runs on base ticks while a divided source is chosen
        if (clock_select >= 3'h1 && clock_select <= 3'h5) begin
            if (base_tick) begin
                next_st.prescale = 10'(st.prescale + 10'h001); // [RULE1]
            end
        end else begin
            next_st.prescale = 10'h000;
        end

        // phase-correct counting; other modes hold the counter here
        if (phase_correct_pwm && tick) begin
            next_st.count = ncnt; // [RULE18]
            next_st.dir   = ndir;
            // match while counting up vs down gives opposite levels
            if (ncnt == st.cmp_act_a) begin
                lvl_a = (ndir == tpw_pkg::TPW_UP) ?
                        up_level(output_mode_a) :
                        ~up_level(output_mode_a); // [RULE2] [RULE20]
                if (output_mode_a[1]) begin
                    next_st.wave_a = lvl_a;
                end
            end
            if (ncnt == st.cmp_act_b) begin
                lvl_b = (ndir == tpw_pkg::TPW_UP) ?
                        up_level(output_mode_b) :
                        ~up_level(output_mode_b); // [RULE2] [RULE20]
                if (output_mode_b[1]) begin
                    next_st.wave_b = lvl_b;
                end
            end
            if (at_bottom) begin
                next_st.ovf = 1'b1; // [RULE19]
            end
            if (at_top) begin
                next_st.cmp_act_a = st.cmp_buf_a; // [RULE19]
                next_st.cmp_act_b = st.cmp_buf_b;
                // settle the down half without a match so the wave stays
                // symmetric about bottom (left 0xff, or missed up-match)
                if (output_mode_a[1]) begin
                    next_st.wave_a = (st.cmp_buf_a != 8'h00 &&
                                      st.cmp_buf_a <= top) ?
                                     up_level(output_mode_a) :
                                     ~up_level(output_mode_a); // [RULE4] [RULE5] [RULE3]
                end
                if (output_mode_b[1]) begin
                    next_st.wave_b = (st.cmp_buf_b != 8'h00 &&
                                      st.cmp_buf_b <= top) ?
                                     up_level(output_mode_b) :
                                     ~up_level(output_mode_b); // [RULE4] [RULE5] [RULE3]
                end
            end
        end

        // dead-time: both pins from channel b, active edges delayed
        if (dead_time_enable) begin
            step_a = dt_step(ref_a, st.out_a, st.dt_cnt_a, st.dead_len,
                             tick); // [RULE6] [RULE21]
            step_b = dt_step(st.wave_b, st.out_b, st.dt_cnt_b,
                             st.dead_len, tick); // [RULE6] [RULE21]
            next_st.out_a    = step_a[8];
            next_st.dt_cnt_a = step_a[7:0];
            next_st.out_b    = step_b[8];
            next_st.dt_cnt_b = step_b[7:0];
        end else begin
            next_st.out_a    = st.wave_a; // [RULE8]
            next_st.out_b    = st.wave_b; // [RULE8]
            next_st.dt_cnt_a = 8'h00;
            next_st.dt_cnt_b = 8'h00;
        end

        // data phase writes; dual-domain set shares the single clock here
        if (wr_en) begin
            case (st.dp_idx)
                `TPW_IDX_IRQ_FLAGS: begin
                    // set wins over the one-to-clear
                    next_st.ovf = next_st.ovf &
                                  ~(wdata[`TPW_FL_OVERFLOW] & ~
                                    (phase_correct_pwm && tick && at_bottom));
                end
                `TPW_IDX_CONTROL_A: begin
                    next_st.control_a = wdata; // [RULE14] [RULE17]
                end
                `TPW_IDX_CONTROL_B: begin
                    next_st.control_b = wdata & `TPW_CB_WR_MASK;
                end
                `TPW_IDX_COUNT_VALUE: begin
                    next_st.count = wdata; // [RULE13]
                end
                `TPW_IDX_COMPARE_A: begin
                    next_st.cmp_buf_a = wdata;
                end
                `TPW_IDX_COMPARE_B: begin
                    next_st.cmp_buf_b = wdata;
                end
                `TPW_IDX_TRIGGER_SEL: begin
                    next_st.trig_sel = wdata;
                end
                `TPW_IDX_DEAD_TIME: begin
                    next_st.dead_len = wdata;
                end
                `TPW_IDX_IRQ_MASK: begin
                    next_st.irq_mask = wdata;
                end
                `TPW_IDX_CLOCK_CTRL: begin
                    next_st.clk_ctl = wdata & 8'h03;
                end
                default: begin
                end
            endcase
        end

        // shutdown latches until control a is rewritten; set wins
        if (wr_en && st.dp_idx == `TPW_IDX_CONTROL_A) begin
            next_st.shut_a = 1'b0;
            next_st.shut_b = 1'b0;
        end
        if (|trig_rise && st.control_a[`TPW_CA_SHUT_A]) begin
            next_st.shut_a = 1'b1; // [RULE16]
        end
        if (|trig_rise && st.control_a[`TPW_CA_SHUT_B]) begin
            next_st.shut_b = 1'b1; // [RULE15]
        end

        // address phase capture; read data taken from the updated copy
        next_st.dp_valid = addr_phase;
        next_st.dp_write = addr_phase && ahb_req.hwrite;
        next_st.dp_hit   = addr_ok;
        next_st.dp_idx   = addr_idx;
        if (addr_phase && !ahb_req.hwrite) begin
            next_st.rdata = addr_ok ? rd_reg(next_st, addr_idx) : 8'h00;
        end
    end

    // single state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // bus answer: zero wait states, always okay
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = 1'b0;
    assign ahb_rsp.hrdata    = {24'h000000, st.rdata};

    // pins: nonzero mode, pin set to output, and not shut down
    assign pins.out_a = st.out_a;
    assign pins.out_b = st.out_b;
    assign pins.oe_a  = (output_mode_a != `TPW_OM_OFF) && pin_dir_a &&
                        !st.shut_a; // [RULE14] [RULE16]
    assign pins.oe_b  = (output_mode_b != `TPW_OM_OFF) && pin_dir_b &&
                        !st.shut_b; // [RULE14] [RULE15]
    assign osc_multiplier_enable = st.clk_ctl[`TPW_CK_MULT_EN]; // [RULE10]

    // checks next to the logic
    property p_ovf_bottom;
        @(posedge sys_clk) disable iff (rst)
        (phase_correct_pwm && tick && st.dir == tpw_pkg::TPW_DOWN &&
         st.count == 8'h01) |=> st.ovf;
    endproperty
    a_ovf_bottom: assert property (p_ovf_bottom) // [RULE19]
        else $error("overflow not set at bottom");

    property p_reload_top;
        @(posedge sys_clk) disable iff (rst)
        (phase_correct_pwm && tick && at_top && !wr_en) |=>
        (st.cmp_act_b == $past(st.cmp_buf_b));
    endproperty
    a_reload_top: assert property (p_reload_top) // [RULE19]
        else $error("compare b not reloaded at top");

    property p_up_match;
        @(posedge sys_clk) disable iff (rst)
        (phase_correct_pwm && tick && output_mode_b == `TPW_OM_CLR_UP &&
         ndir == tpw_pkg::TPW_UP && ncnt == st.cmp_act_b && !at_top)
        |=> !st.wave_b;
    endproperty
    a_up_match: assert property (p_up_match) // [RULE2]
        else $error("up-count match did not clear b");

    property p_top_fix;
        @(posedge sys_clk) disable iff (rst)
        (phase_correct_pwm && tick && at_top &&
         output_mode_a == `TPW_OM_SET_UP && st.cmp_buf_a != 8'h00 &&
         st.cmp_buf_a <= top) |=> st.wave_a;
    endproperty
    a_top_fix: assert property (p_top_fix) // [RULE4]
        else $error("no symmetry correction at top");

    property p_fall_now;
        @(posedge sys_clk) disable iff (rst)
        (dead_time_enable && !st.wave_b) |=> !st.out_b;
    endproperty
    a_fall_now: assert property (p_fall_now) // [RULE21]
        else $error("inactive edge delayed");

    property p_dead_wait;
        @(posedge sys_clk) disable iff (rst)
        (dead_time_enable && st.dead_len != 8'h00 && $rose(st.wave_b) &&
         $stable(st.dead_len)) |-> !st.out_b ##1 !st.out_b;
    endproperty
    a_dead_wait: assert property (p_dead_wait) // [RULE21]
        else $error("active edge not delayed");

    property p_polarity;
        @(posedge sys_clk) disable iff (rst)
        (dead_time_enable && output_mode_a != output_mode_b && st.wave_b &&
         $stable(st.control_a)) |=> !st.out_a;
    endproperty
    a_polarity: assert property (p_polarity) // [RULE7]
        else $error("output a polarity wrong");

    property p_no_dead;
        @(posedge sys_clk) disable iff (rst)
        !dead_time_enable |=> (st.out_a == $past(st.wave_a));
    endproperty
    a_no_dead: assert property (p_no_dead) // [RULE8]
        else $error("output a not following its channel");

    property p_shut_b;
        @(posedge sys_clk) disable iff (rst)
        (|trig_rise && st.control_a[`TPW_CA_SHUT_B]) |=> !pins.oe_b;
    endproperty
    a_shut_b: assert property (p_shut_b) // [RULE15]
        else $error("channel b not shut down");

    property p_shut_a;
        @(posedge sys_clk) disable iff (rst)
        (|trig_rise && st.control_a[`TPW_CA_SHUT_A]) |=> !pins.oe_a;
    endproperty
    a_shut_a: assert property (p_shut_a) // [RULE16]
        else $error("channel a not shut down");

    property p_fast_tick;
        @(posedge sys_clk) disable iff (rst)
        (fast_clock_select && st.fast_sync[1] == st.fast_prev) |-> !tick;
    endproperty
    a_fast_tick: assert property (p_fast_tick) // [RULE9]
        else $error("tick without fast clock edge");

endmodule

// ---- verification/testbench.sv ----
// self-checking bench: registers, pwm shape, dead time, shutdown
// assumes hreadyout is looped back to hready, one system clock
`timescale 1ns/10ps
`include "tpw_defs.svh"

module testbench;
    logic                  sys_clk = 0, rst = 1, fast = 0, fon = 0;
    logic                  dir_a = 1, dir_b = 1, mul_en, shoot;
    logic [7:0]            trg = 0, q, c, d;
    tpw_pkg::tpw_ahb_req_t rq = '0, rqw;
    tpw_pkg::tpw_ahb_rsp_t rsp;
    tpw_pkg::tpw_pins_t    pins;
    int                    error_cnt = 0, n_checks = 0, ha, hb, sh, ps;
    logic [31:0]           seed = 32'd91703;
    logic [7:0]            ix [10] = '{`TPW_IDX_IRQ_FLAGS,
        `TPW_IDX_CONTROL_A, `TPW_IDX_CONTROL_B, `TPW_IDX_COUNT_VALUE,
        `TPW_IDX_COMPARE_A, `TPW_IDX_COMPARE_B, `TPW_IDX_TRIGGER_SEL,
        `TPW_IDX_DEAD_TIME, `TPW_IDX_IRQ_MASK, `TPW_IDX_CLOCK_CTRL};

    // clocks; the fast one has an unrelated period
    always #20 sys_clk = ~sys_clk;
    always #83 fast = fon & ~fast;

    // single slave: its hreadyout is the bus hready
    always_comb begin
        rqw = rq;
        rqw.hready = rsp.hreadyout;
    end

    tpw_timer dut_u (.sys_clk(sys_clk), .rst(rst), .ahb_req(rqw),
        .ahb_rsp(rsp), .fast_rc_osc_clock(fast), .trigger_events(trg),
        .pin_dir_a(dir_a), .pin_dir_b(dir_b),
        .osc_multiplier_enable(mul_en), .pins(pins));
    tpw_bridge stage_u (.sys_clk(sys_clk), .pins(pins), .shoot(shoot));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // high cycles per 510-tick period, clear-on-up-match channel;
    // compare at 0 or 0xff pins the output at the far level
    function automatic int hi(logic [7:0] cm, logic inv, int dt);
        int e;
        e = cm == 8'h00 ? 255 : cm == 8'hff ? 0 : int'(cm);
        return (inv ? 510 - 2 * e : 2 * e) - dt;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t got %0h want %0h", $time, got, exp);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic rdy();
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rsp.hreadyout !== 1'b1 && k < 40);
        if (k >= 40) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    // one word transfer; each leaves a gap cycle before the next
    task automatic xfer(input logic [7:0] x, input logic w,
                        input logic [7:0] wd);
        rq.hsel <= 1'b1;
        rq.htrans <= 2'h2;
        rq.haddr <= {2'h0, x, 2'h0};
        rq.hwrite <= w;
        rdy();
        rq.htrans <= 2'h0;
        rq.hwdata <= {24'h0, wd};
        rdy();
        q = rsp.hrdata[7:0];
    endtask

    // high cycles of both pins and of shoot-through over n cycles
    task automatic meas(input int n);
        ha = 0;
        hb = 0;
        sh = 0;
        repeat (n) begin
            @(posedge sys_clk);
            ha += pins.out_a;
            hb += pins.out_b;
            sh += shoot;
        end
    endtask

    initial begin
        rq.hsize = 3'h2;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (ix[i]) begin
            xfer(ix[i], 0, 0);
            chk(q, `TPW_REG_RESET);
        end
        for (int i = 4; i < 9; i++) begin
            d = rnd();
            xfer(ix[i], 1, d);
            xfer(ix[i], 0, 0);
            chk(q, d);
        end
        xfer(`TPW_IDX_CONTROL_B, 1, 8'hff);
        xfer(`TPW_IDX_CONTROL_B, 0, 0);
        chk(q, `TPW_CB_WR_MASK);
        xfer(8'h00, 0, 0);
        chk(q, 0);
        // independent channels: extremes, random, two prescales
        for (int i = 0; i < 4; i++) begin
            c = i == 0 ? 8'h00 : i == 1 ? 8'hff : rnd();
            d = rnd();
            ps = i < 2 ? 1 : 8;
            xfer(`TPW_IDX_COMPARE_A, 1, c);
            xfer(`TPW_IDX_COMPARE_B, 1, d);
            xfer(`TPW_IDX_CONTROL_A, 1, 8'hb1);
            xfer(`TPW_IDX_CONTROL_B, 1, i < 2 ? 8'h01 : 8'h02);
            repeat (1020 * ps) @(posedge sys_clk);
            meas(510 * ps);
            chk(ha, ps * hi(c, 0, 0));
            chk(hb, ps * hi(d, 1, 0));
            chk(pins.oe_a, 1);
        end
        // dead time from channel b, opposite then equal polarity
        c = rnd();
        d = {2'h1, c[5:0]};
        c = {4'h0, c[3:0]};
        xfer(`TPW_IDX_COMPARE_B, 1, d);
        xfer(`TPW_IDX_DEAD_TIME, 1, c);
        xfer(`TPW_IDX_CONTROL_B, 1, 8'h11);
        for (int j = 0; j < 2; j++) begin
            xfer(`TPW_IDX_CONTROL_A, 1, j ? 8'ha1 : 8'he1);
            repeat (1020) @(posedge sys_clk);
            meas(510);
            chk(hb, hi(d, 0, c));
            chk(ha, hi(d, j == 0, c));
            if (j == 0) chk(sh, 0);
        end
        // trigger shutdown of one channel at a time
        xfer(`TPW_IDX_TRIGGER_SEL, 1, 8'h01);
        for (int j = 0; j < 2; j++) begin
            xfer(`TPW_IDX_CONTROL_A, 1, j ? 8'ha5 : 8'ha9);
            trg <= 8'h01;
            repeat (3) @(posedge sys_clk);
            trg <= 8'h00;
            chk(pins.oe_a, j == 0);
            chk(pins.oe_b, j == 1);
        end
        dir_b <= 1'b0;
        @(posedge sys_clk);
        chk(pins.oe_b, 0);
        // fast clock: multiplier first, then select; stop to read
        fon = 1;
        xfer(`TPW_IDX_CLOCK_CTRL, 1, 8'h01);
        repeat (20) @(posedge sys_clk);
        chk(mul_en, 1);
        xfer(`TPW_IDX_CLOCK_CTRL, 1, 8'h03);
        xfer(`TPW_IDX_CONTROL_B, 1, 8'h01);
        repeat (600) @(posedge sys_clk);
        xfer(`TPW_IDX_CONTROL_B, 1, 8'h00);
        xfer(`TPW_IDX_COUNT_VALUE, 0, 0);
        c = q;
        repeat (20) @(posedge sys_clk);
        xfer(`TPW_IDX_COUNT_VALUE, 0, 0);
        chk(q, c);
        xfer(`TPW_IDX_IRQ_FLAGS, 0, 0);
        chk(q[0], 1);
        xfer(`TPW_IDX_IRQ_FLAGS, 1, 8'h01);
        xfer(`TPW_IDX_IRQ_FLAGS, 0, 0);
        chk(q[0], 0);
        tally_and_finish();
    end
endmodule

// ---- verification/tpw_bridge.sv ----
// half-bridge gate model fed by the two compare pins
// assumes active-high gates sampled on the system clock
`timescale 1ns/10ps

module tpw_bridge (
    input  wire logic               sys_clk,
    input  wire tpw_pkg::tpw_pins_t pins,
    output logic                    shoot
);
    // both gates on together would short the supply rail
    always_ff @(posedge sys_clk) begin
        shoot <= pins.oe_a & pins.oe_b & pins.out_a & pins.out_b;
    end
endmodule
